// ### opf_params.svh
// constants for the optical path failover controller
`ifndef OPF_PARAMS_SVH
`define OPF_PARAMS_SVH
`define OPF_CLK_HZ      40000000
`define OPF_SEC_CYCLES  (`OPF_CLK_HZ * 1)
`define OPF_SETTLE_MS   10
`define OPF_SETTLE_CYC  (`OPF_CLK_HZ / 1000 * `OPF_SETTLE_MS)
`define OPF_A_CTRL      8'h00
`define OPF_A_THRA      8'h04
`define OPF_A_THRB      8'h08
`define OPF_A_HYST      8'h0C
`define OPF_A_HOLD      8'h10
`define OPF_A_STAT      8'h14
`define OPF_A_PWRA      8'h18
`define OPF_A_PWRB      8'h1C
`define OPF_C_MODE      0
`define OPF_C_REVERT    1
`define OPF_C_PRIM      2
`define OPF_C_POS       3
`define OPF_CTRL_RST    4'h2
`define OPF_THR_RST     16'h0032
`define OPF_THR_MIN     16'hFF9C
`define OPF_THR_MAX     16'h008C
`define OPF_HYST_RST    16'h000A
`define OPF_HYST_MIN    16'h0005
`define OPF_HYST_MAX    16'h005F
`define OPF_HOLD_RST    16'h003C
`define OPF_HOLD_MIN    16'h0000
`define OPF_HOLD_MAX    16'h0258
`define OPF_EXCESS      16'h00F0
`define OPF_S_POS       0
`define OPF_S_LOLA      1
`define OPF_S_LOLB      2
`define OPF_S_DARK      3
`define OPF_S_NOSW      4
`define OPF_S_SUPPLY    5
`define OPF_S_EXCESS    6
`define OPF_RESP_OKAY   2'h0
`define OPF_RESP_SLVERR 2'h2
`endif

// ### opf_pkg.sv
// types shared by the failover controller files
package opf_pkg;
  typedef enum logic {OPF_AUTO, OPF_MANUAL} opf_mode_e;
  typedef logic signed [15:0] opf_pwr_t;
endpackage

// ### opf_hold_timer.sv
// restore hold timer counting whole seconds
`include "opf_params.svh"
module opf_hold_timer
  import opf_pkg::*;
#(
  parameter int TICKS_PER_SEC = `OPF_SEC_CYCLES
) (
  input  logic       clk,
  input  logic       rst_n,
  input  logic       run,
  input  logic [9:0] holdSec,
  output logic       expired
);
  localparam int TW = $clog2(TICKS_PER_SEC + 1);
  localparam logic [TW-1:0] TLAST = TW'(TICKS_PER_SEC - 1);

  logic [TW-1:0] tick_q;
  logic [9:0]    sec_q;

  // dropping below the restore level wipes the count
  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      tick_q <= '0;
      sec_q  <= '0;
    end else if (sec_q < holdSec) begin
      if (tick_q == TLAST) begin
        tick_q <= '0;
        sec_q  <= sec_q + 10'h001;
      end else begin
        tick_q <= tick_q + TW'(1);
      end
    end
  end

  assign expired = run && (sec_q >= holdSec);

  timerCancel_a: assert property (@(posedge clk) disable iff (!rst_n)
    !run |=> (sec_q == 10'h000) && (tick_q == '0))
    else $error("hold timer not cleared after restore level lost");
endmodule

// ### opf_ctrl.sv
// optical protection switch controller with AXI4-Lite registers
//
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`include "opf_params.svh"
module opf_ctrl
  import opf_pkg::*;
#(
  parameter int TICKS_PER_SEC = `OPF_SEC_CYCLES,
  parameter int SETTLE_CYC    = `OPF_SETTLE_CYC
) (
  input  logic        clk,
  input  logic        rst_n,
  input  logic [7:0]  s_axi_awaddr,
  input  logic        s_axi_awvalid,
  output logic        s_axi_awready,
  input  logic [31:0] s_axi_wdata,
  input  logic [3:0]  s_axi_wstrb,
  input  logic        s_axi_wvalid,
  output logic        s_axi_wready,
  output logic [1:0]  s_axi_bresp,
  output logic        s_axi_bvalid,
  input  logic        s_axi_bready,
  input  logic [7:0]  s_axi_araddr,
  input  logic        s_axi_arvalid,
  output logic        s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0]  s_axi_rresp,
  output logic        s_axi_rvalid,
  input  logic        s_axi_rready,
  input  opf_pwr_t    powerA,
  input  opf_pwr_t    powerB,
  input  logic        posSense,
  input  logic        railsOk,
  output logic        switchSel
);
  localparam int SW = $clog2(SETTLE_CYC + 1);
  localparam logic [SW-1:0] SLAST = SW'(SETTLE_CYC - 1);

  ////////////////////////////////////////////////////////////////////////
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= `OPF_A_PWRB);
  endfunction

  function automatic logic [15:0] clampVal(input logic [15:0] v, input logic [15:0] lo,
                                           input logic [15:0] hi);
    if ($signed(v) < $signed(lo)) begin
      clampVal = lo;
    end else if ($signed(v) > $signed(hi)) begin
      clampVal = hi;
    end else begin
      clampVal = v;
    end
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  logic [7:0]  awAddr_q;
  logic [31:0] wData_q;
  logic [3:0]  wStrb_q;
  logic        awHeld_q;
  logic        wHeld_q;
  logic        doWr;

  assign doWr = awHeld_q && wHeld_q && !s_axi_bvalid;

  // address and data are taken in either order, response after both
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      awAddr_q      <= 8'h00;
      wData_q       <= 32'h0000_0000;
      wStrb_q       <= 4'h0;
      awHeld_q      <= 1'b0;
      wHeld_q       <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `OPF_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_q      <= s_axi_awaddr;
        awHeld_q      <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_q      <= s_axi_wdata;
        wStrb_q      <= s_axi_wstrb;
        wHeld_q      <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (doWr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awAddr_q) ? `OPF_RESP_OKAY : `OPF_RESP_SLVERR;
        awHeld_q     <= 1'b0;
        wHeld_q      <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  logic [3:0]  ctrl_q;
  logic [15:0] thrA_q;
  logic [15:0] thrB_q;
  logic [15:0] hyst_q;
  logic [15:0] hold_q;
  logic [31:0] ctrlNew;
  logic        ctrlWr;
  opf_mode_e   mode;

  assign ctrlNew = merge({28'h0000000, ctrl_q}, wData_q, wStrb_q);
  assign ctrlWr  = doWr && (awAddr_q == `OPF_A_CTRL);
  assign mode    = opf_mode_e'(ctrl_q[`OPF_C_MODE]);

  // out-of-range settings are clamped to the nearest legal value
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q <= `OPF_CTRL_RST;
      thrA_q <= `OPF_THR_RST;
      thrB_q <= `OPF_THR_RST;
      hyst_q <= `OPF_HYST_RST;
      hold_q <= `OPF_HOLD_RST;
    end else if (doWr) begin
      case (awAddr_q)
        `OPF_A_CTRL: ctrl_q <= ctrlNew[3:0];
        `OPF_A_THRA: thrA_q <= clampVal(16'(merge({16'h0000, thrA_q}, wData_q, wStrb_q)),
                                        `OPF_THR_MIN, `OPF_THR_MAX);
        `OPF_A_THRB: thrB_q <= clampVal(16'(merge({16'h0000, thrB_q}, wData_q, wStrb_q)),
                                        `OPF_THR_MIN, `OPF_THR_MAX);
        `OPF_A_HYST: hyst_q <= clampVal(16'(merge({16'h0000, hyst_q}, wData_q, wStrb_q)),
                                        `OPF_HYST_MIN, `OPF_HYST_MAX);
        `OPF_A_HOLD: hold_q <= clampVal(16'(merge({16'h0000, hold_q}, wData_q, wStrb_q)),
                                        `OPF_HOLD_MIN, `OPF_HOLD_MAX);
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  opf_pwr_t pwr [2];
  opf_pwr_t thr [2];
  logic [1:0] low;
  logic [1:0] over;

  assign pwr[0] = powerA;
  assign pwr[1] = powerB;
  assign thr[0] = opf_pwr_t'(thrA_q);
  assign thr[1] = opf_pwr_t'(thrB_q);

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gPath
      assign low[g]  = pwr[g] < thr[g];
      assign over[g] = pwr[g] >= opf_pwr_t'(`OPF_EXCESS);
    end
  endgenerate

  logic     prim;
  logic     onPrim;
  logic     lowP;
  logic     lowS;
  logic     aboveRestore;
  logic     runHold;
  logic     holdDone;
  logic     pos_d;
  logic     pos_q;

  assign prim   = ctrl_q[`OPF_C_PRIM];
  assign onPrim = (pos_q == prim);
  assign lowP   = low[prim];
  assign lowS   = low[!prim];
  assign aboveRestore = 17'(signed'(pwr[prim])) > 17'(signed'(thr[prim])) + 17'(signed'(hyst_q));
  assign runHold = (mode == OPF_AUTO) && ctrl_q[`OPF_C_REVERT] && !onPrim && aboveRestore;

  opf_hold_timer #(
    .TICKS_PER_SEC (TICKS_PER_SEC)
  ) u_opf_hold_timer (
    .clk     (clk),
    .rst_n   (rst_n),
    .run     (runHold),
    .holdSec (hold_q[9:0]),
    .expired (holdDone)
  );

  always_comb begin
    pos_d = pos_q;
    if (ctrlWr) begin
      if (ctrlNew[`OPF_C_MODE]) begin
        pos_d = ctrlNew[`OPF_C_POS];
      end
    end else if (mode == OPF_AUTO) begin
      if (lowP && lowS) begin
        pos_d = prim;
      end else if (lowP) begin
        pos_d = !prim;
      end else if (lowS || onPrim) begin
        pos_d = prim;
      end else if (ctrl_q[`OPF_C_REVERT] && holdDone) begin
        pos_d = prim;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pos_q     <= 1'b0;
      switchSel <= 1'b0;
    end else begin
      pos_q     <= pos_d;
      switchSel <= pos_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // the switch is mechanical, so a fresh command gets time to settle
  logic [SW-1:0] settle_q;
  logic          settling_q;
  logic          noSw_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      settle_q   <= '0;
      settling_q <= 1'b0;
      noSw_q     <= 1'b0;
    end else if (pos_d != pos_q) begin
      settle_q   <= '0;
      settling_q <= 1'b1;
    end else if (settling_q) begin
      if (settle_q == SLAST) begin
        settling_q <= 1'b0;
        noSw_q     <= (posSense != pos_q);
      end else begin
        settle_q <= settle_q + SW'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  logic [6:0] stat_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stat_q <= 7'h00;
    end else begin
      stat_q[`OPF_S_POS]    <= posSense;
      stat_q[`OPF_S_LOLA]   <= !low[0];
      stat_q[`OPF_S_LOLB]   <= !low[1];
      stat_q[`OPF_S_DARK]   <= !(low[0] && low[1]);
      stat_q[`OPF_S_NOSW]   <= !noSw_q;
      stat_q[`OPF_S_SUPPLY] <= railsOk;
      stat_q[`OPF_S_EXCESS] <= !(|over);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] readMux(input logic [7:0] a);
    case (a)
      `OPF_A_CTRL: readMux = {28'h0000000, ctrl_q};
      `OPF_A_THRA: readMux = {{16{thrA_q[15]}}, thrA_q};
      `OPF_A_THRB: readMux = {{16{thrB_q[15]}}, thrB_q};
      `OPF_A_HYST: readMux = {16'h0000, hyst_q};
      `OPF_A_HOLD: readMux = {16'h0000, hold_q};
      `OPF_A_STAT: readMux = {25'h0, stat_q};
      `OPF_A_PWRA: readMux = {{16{powerA[15]}}, powerA};
      `OPF_A_PWRB: readMux = {{16{powerB[15]}}, powerB};
      default:     readMux = 32'h0000_0000;
    endcase
  endfunction

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `OPF_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= readMux(s_axi_araddr);
      s_axi_rresp   <= mapped(s_axi_araddr) ? `OPF_RESP_OKAY : `OPF_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  autoFailover_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mode == OPF_AUTO) && !ctrlWr && onPrim && lowP && !lowS |=> (pos_q != $past(prim)))
    else $error("primary loss did not move switch to backup");

  manualHold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mode == OPF_MANUAL) && !ctrlWr |=> $stable(pos_q))
    else $error("switch moved in manual mode without command");

  resetDefaults_a: assert property (@(posedge clk)
    !rst_n |=> (ctrl_q == `OPF_CTRL_RST) && (thrA_q == `OPF_THR_RST) && (hold_q == `OPF_HOLD_RST))
    else $error("settings not at defaults after reset");

  primaryHeld_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mode == OPF_AUTO) && !ctrlWr && !lowP ##1 (mode == OPF_AUTO) && !ctrlWr && onPrim && !lowP
    |=> onPrim)
    else $error("switch left healthy primary");

  bothDark_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mode == OPF_AUTO) && !ctrlWr && lowP && lowS |=> (pos_q == $past(prim)) && !stat_q[`OPF_S_DARK])
    else $error("both dark not handled");

  lossFlag_a: assert property (@(posedge clk) disable iff (!rst_n)
    low[0] |=> !stat_q[`OPF_S_LOLA])
    else $error("path A loss of light not reported");

  excessPower_a: assert property (@(posedge clk) disable iff (!rst_n)
    (powerA >= opf_pwr_t'(`OPF_EXCESS)) || (powerB >= opf_pwr_t'(`OPF_EXCESS))
    |=> !stat_q[`OPF_S_EXCESS])
    else $error("excessive power not reported");

  noRevert_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mode == OPF_AUTO) && !ctrlWr && !ctrl_q[`OPF_C_REVERT] && !onPrim && !lowS |=> $stable(pos_q))
    else $error("switch reverted with revert off");

  supplyFlag_a: assert property (@(posedge clk) disable iff (!rst_n)
    !railsOk |=> !stat_q[`OPF_S_SUPPLY])
    else $error("supply failure not reported");
endmodule

// ### opf_switch_model.sv
// behavioural optical switch: sensed position trails the command
module opf_switch_model (
  input  wire logic clk,
  input  wire logic stuck,
  input  wire logic slow,
  input  wire logic switchSel,
  output logic      posSense
);
  timeunit 1ns;
  timeprecision 1ps;
  logic midQ = 1'b0;
  logic senseQ = 1'b0;
  assign posSense = senseQ;
  // a stuck mechanism keeps its last position, so the controller must notice
  always @(posedge clk) begin
    midQ <= switchSel;
    if (!stuck) senseQ <= slow ? midQ : switchSel;
  end
endmodule

// ### opf_ctrl_test.sv
// self-checking bench for the optical path failover controller
module opf_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  import opf_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready = 1'b1;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready = 1'b1;
  opf_pwr_t    powerA = 16'h0050;
  opf_pwr_t    powerB = 16'h0050;
  logic        posSense;
  logic        railsOk = 1'b1;
  logic        switchSel;
  logic        stuck = 1'b0;
  logic        slow = 1'b0;
  int          failures = 0;
  int          samplesChecked = 0;

  // short second and settle counts keep the run brief
  opf_ctrl #(.TICKS_PER_SEC(10), .SETTLE_CYC(4)) u_opf_ctrl (
    .clk(clk), .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .powerA(powerA), .powerB(powerB),
    .posSense(posSense), .railsOk(railsOk), .switchSel(switchSel)
  );
  opf_switch_model u_opf_switch_model (
    .clk(clk), .stuck(stuck), .slow(slow), .switchSel(switchSel), .posSense(posSense)
  );

  always #12.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("failures %0d samplesChecked %0d", failures, samplesChecked);
    if (failures == 0 && samplesChecked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samplesChecked++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // only the watchdog ends a hung bus wait
  task automatic axWrite(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input string nm);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    chk("rresp", (a > 8'h1C || a[1:0] != 2'h0) ? 32'h2 : 32'h0, {30'h0, s_axi_rresp});
    chk(nm, e, s_axi_rdata);
  endtask

  task automatic waitSel(input logic v, input int lim);
    int n;
    n = 0;
    while (switchSel !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk("switchSel", {31'h0, v}, {31'h0, switchSel});
  endtask

  task automatic setPw(input int a, input int b);
    powerA <= 16'(a);
    powerB <= 16'(b);
  endtask

  // expected status word; thresholds are the bench's own settings
  function automatic logic [31:0] stat(input logic p, input logic ns, input logic rl, input int a, input int b);
    logic la;
    logic lb;
    la = a >= 50;
    lb = b >= 50;
    return {25'h0, (a < 240 && b < 240), rl, ns, (la | lb), lb, la, p};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  task automatic tResetVals();
    logic [7:0]  ad [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
    logic [31:0] ev [5] = '{32'h2, 32'h32, 32'h32, 32'hA, 32'h3C};
    for (int i = 0; i < 5; i++) rdChk(ad[i], ev[i], "reset value");
    rdChk(8'h14, stat(1'b0, 1'b1, 1'b1, 80, 80), "status");
    rdChk(8'h1C, 32'h50, "power B");
    rdChk(8'h20, 32'h0, "unmapped read");
    chk("switchSel", 32'h0, {31'h0, switchSel});
  endtask

  task automatic tClamp();
    logic [7:0]  ad [6] = '{8'h04, 8'h08, 8'h0C, 8'h0C, 8'h10, 8'h08};
    logic [31:0] wv [6] = '{32'hFFFFFF38, 32'h12C, 32'h1, 32'hC8, 32'h3E8, 32'h32};
    logic [31:0] ev [6] = '{32'hFFFFFF9C, 32'h8C, 32'h5, 32'h5F, 32'h258, 32'h32};
    for (int i = 0; i < 6; i++) begin
      axWrite(ad[i], wv[i], 2'h0);
      rdChk(ad[i], ev[i], "limited setting");
    end
    axWrite(8'h04, 32'h32, 2'h0);
    axWrite(8'h20, 32'h1, 2'h2);
    axWrite(8'h05, 32'h1, 2'h2);
    rdChk(8'h04, 32'h32, "threshold A kept");
    axWrite(8'h0C, 32'hA, 2'h0);
    axWrite(8'h10, 32'h5, 2'h0);
  endtask

  task automatic tFailover();
    setPw(-30, 80);
    waitSel(1'b1, 20);
    repeat (10) @(posedge clk);
    rdChk(8'h14, stat(1'b1, 1'b1, 1'b1, -30, 80), "status");
    rdChk(8'h18, 32'hFFFFFFE2, "power A");
  endtask

  // hold 5 s: restarted run must not finish early, uncancelled run would
  task automatic tRevert();
    setPw(55, 80);
    repeat (60) @(posedge clk);
    chk("switchSel", 32'h1, {31'h0, switchSel});
    setPw(70, 80);
    repeat (35) @(posedge clk);
    setPw(55, 80);
    repeat (2) @(posedge clk);
    setPw(70, 80);
    repeat (20) @(posedge clk);
    chk("switchSel", 32'h1, {31'h0, switchSel});
    waitSel(1'b0, 50);
    axWrite(8'h00, 32'h0, 2'h0);
    setPw(-30, 80);
    waitSel(1'b1, 20);
    setPw(80, 80);
    repeat (80) @(posedge clk);
    chk("switchSel", 32'h1, {31'h0, switchSel});
    axWrite(8'h00, 32'h2, 2'h0);
    waitSel(1'b0, 70);
  endtask

  task automatic tPrimaryB();
    axWrite(8'h00, 32'h6, 2'h0);
    // a newly designated primary is reached through the revert hold time
    waitSel(1'b1, 70);
    setPw(80, -30);
    waitSel(1'b0, 20);
    setPw(-30, -30);
    waitSel(1'b1, 20);
    repeat (10) @(posedge clk);
    rdChk(8'h14, stat(1'b1, 1'b1, 1'b1, -30, -30), "status");
    axWrite(8'h00, 32'h2, 2'h0);
    waitSel(1'b0, 20);
    setPw(80, 80);
  endtask

  task automatic tManual();
    axWrite(8'h00, 32'h3, 2'h0);
    setPw(-30, 80);
    repeat (20) @(posedge clk);
    chk("switchSel", 32'h0, {31'h0, switchSel});
    axWrite(8'h00, 32'hB, 2'h0);
    waitSel(1'b1, 4);
    axWrite(8'h00, 32'h3, 2'h0);
    waitSel(1'b0, 4);
    axWrite(8'h00, 32'h2, 2'h0);
    waitSel(1'b1, 20);
    setPw(80, 80);
    waitSel(1'b0, 70);
  endtask

  task automatic tAlarms();
    railsOk <= 1'b0;
    slow <= 1'b1;
    setPw(240, 80);
    repeat (4) @(posedge clk);
    rdChk(8'h14, stat(1'b0, 1'b1, 1'b0, 240, 80), "status");
    railsOk <= 1'b1;
    setPw(80, 239);
    repeat (4) @(posedge clk);
    rdChk(8'h14, stat(1'b0, 1'b1, 1'b1, 80, 239), "status");
    stuck <= 1'b1;
    axWrite(8'h00, 32'hB, 2'h0);
    waitSel(1'b1, 4);
    repeat (20) @(posedge clk);
    rdChk(8'h14, stat(1'b0, 1'b0, 1'b1, 80, 239), "status");
    axWrite(8'h00, 32'h3, 2'h0);
    repeat (20) @(posedge clk);
    rdChk(8'h14, stat(1'b0, 1'b1, 1'b1, 80, 239), "status");
    stuck <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    tResetVals();
    tClamp();
    tFailover();
    tRevert();
    tPrimaryB();
    tManual();
    tAlarms();
    results();
  end

  // whole run needs about 600 cycles
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    results();
  end
endmodule
